// *** rtl/adc_mode_control_map.vh ***
// Purpose: constants of the converter mode register and its sequencer
// Assumes: included by adc_mode_control.v
// Notes: offsets, fields, codes and timing figures
`ifndef ADC_MODE_CONTROL_MAP_VH
`define ADC_MODE_CONTROL_MAP_VH

// ****************************************************************
// register addresses and reset value
// ****************************************************************
`define OPERATING_MODE_ADDR 4'h1
`define OPERATING_MODE_RESET 8'h00

// ****************************************************************
// field positions of operating_mode
// ****************************************************************
`define MODE_BIT_SEVEN 7
`define BUF_BYPASS_BIT 6
`define RSVD_FIVE_BIT 5
`define CHANNEL_CONFIG_BIT 4
`define OSC_STOP_BIT 3
`define MODE_FIELD_HI 2
`define MODE_FIELD_LO 0
`define MODE_WRITE_MASK 8'h5F

// ****************************************************************
// command byte layout
// ****************************************************************
`define CMD_READ_BIT 6
`define CMD_ADDR_HI 3
`define CMD_ADDR_LO 0

// ****************************************************************
// operating_mode_field codes
// ****************************************************************
`define MD_POWER_DOWN 3'h0
`define MD_IDLE 3'h1
`define MD_SINGLE 3'h2
`define MD_CONTINUOUS 3'h3
`define MD_INT_ZERO_CAL 3'h4
`define MD_INT_FULL_CAL 3'h5
`define MD_SYS_ZERO_CAL 3'h6
`define MD_SYS_FULL_CAL 3'h7

// ****************************************************************
// timing
// ****************************************************************
// 300 ms restart at the 50 MHz system clock, sized to the counter
`define OSC_START_CYCLES 24'hE4E1C0

`endif

// *** rtl/adc_mode_control.v ***
// Purpose: mode register and operating-mode sequencer of a dual converter
// Assumes: serial clock, select and data arrive from outside the domain
// Notes: modulator and filter report completion on conv/cal done pulses
//        restart time is a parameter so a bench may shorten it
//
// Operation
// RQ1: eight-bit read/write mode register, cleared to zero at reset.
// RQ2: mode register shifted most significant bit first, descending order.
// RQ3: bit six set bypasses input buffer; clear uses buffered path.
// RQ4: channel bit set: three pseudo-differential main, aux loses pair.
// RQ5: channel bit clear: two differential main, aux keeps pair options.
// RQ6: oscillator-stop set halts crystal in standby; 300 ms restart.
// RQ7: oscillator-stop clear keeps crystal running, no restart delay.
// RQ8: mode code zero is power-down: sources, switches and PLL off.
// RQ9: idle holds filter and modulator in reset, modulator clocks run.
// RQ10: single conversion updates data, writes status, returns to idle.
// RQ11: continuous conversion updates data on each filter-rate result.
// RQ12: internal zero calibration shorts inputs, then returns to idle.
// RQ13: internal full calibration connects reference, then returns to idle.
// RQ14: host applies system zero input before code six.
// RQ15: host applies system full input before code seven.
// RQ16: any mode-field write resets both converters, even unchanged.
// RQ17: calibration write clears ready flags; done writes regs, goes idle.
// RQ18: reserved bits seven and five are written as and read as zero.
`timescale 1ns/1ps
`include "adc_mode_control_map.vh"

module adc_mode_control #(
   parameter [23:0] OSC_START_CYCLES = `OSC_START_CYCLES
)(
   input wire sys_clk_in, // system clock, 50 MHz
   input wire sys_rst_in, // async reset, active high
   input wire sclk_in, // serial clock pin
   input wire cs_n_in, // serial select pin, active low
   input wire din_in, // serial data in pin
   input wire conv_done_in, // converter result ready pulse
   input wire cal_done_in, // calibration finished pulse
   output reg dout_out, // serial data out
   output reg [2:0] operating_mode_field_out, // current mode code
   output reg buf_bypass_out, // input buffer bypassed
   output reg main_pseudo_diff_out, // main uses three pseudo channels
   output reg aux_pair_avail_out, // aux may use third/fourth pair
   output reg osc_run_out, // crystal oscillator enable
   output reg osc_ready_out, // crystal oscillating and settled
   output reg pll_enable_out, // PLL, sources and switches powered
   output reg conv_hold_reset_out, // filter and modulator held in reset
   output reg conv_reset_out, // pulse: reset both converters
   output reg ready_clear_out, // pulse: clear conversion_ready_flags
   output reg data_update_out, // pulse: load data registers
   output reg status_write_out, // pulse: write status flags
   output reg cal_reg_write_out, // pulse: write calibration registers
   output reg cal_active_out, // calibration in progress
   output reg short_inputs_out, // internal short on inputs
   output reg ref_to_input_out // reference routed to input
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   reg [2:0] sclk_sync_q;
   reg [2:0] cs_sync_q;
   reg [2:0] din_sync_q;
   reg sclk_q;
   reg cs_n_q;

   always @(posedge sys_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         sclk_sync_q <= 3'h0;
         // select resets high so no frame starts during reset
         cs_sync_q <= 3'h7;
         din_sync_q <= 3'h0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
      end
      else
      begin
         sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
         cs_sync_q <= {cs_sync_q[1:0], cs_n_in};
         din_sync_q <= {din_sync_q[1:0], din_in};
         // a change counts once the second and third stages agree
         if (sclk_sync_q[1] == sclk_sync_q[2])
            sclk_q <= sclk_sync_q[2];
         if (cs_sync_q[1] == cs_sync_q[2])
            cs_n_q <= cs_sync_q[2];
      end
   end

   // ****************************************************************
   // serial clock edges
   // ****************************************************************
   // edges count only while selected, so the detector's reset level
   // cannot fake a bit whichever level the clock idles at
   wire sclk_rise = sclk_sync_q[1] & sclk_sync_q[2] & ~sclk_q;
   wire sclk_fall = ~sclk_sync_q[1] & ~sclk_sync_q[2] & sclk_q;

   // ****************************************************************
   // serial framing: command byte, then one data byte
   // ****************************************************************
   reg [3:0] bit_cnt_q;
   reg [7:0] shift_in_q;
   reg [7:0] shift_out_q;
   reg is_read_q;
   reg hit_mode_q;
   reg host_write_q;
   reg [7:0] host_data_q;
   reg [7:0] mode_q;

   wire [7:0] rx_byte = {shift_in_q[6:0], din_sync_q[2]};

   always @(posedge sys_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         bit_cnt_q <= 4'h0;
         shift_in_q <= 8'h00;
         shift_out_q <= 8'h00;
         is_read_q <= 1'b0;
         hit_mode_q <= 1'b0;
         host_write_q <= 1'b0;
         host_data_q <= 8'h00;
         dout_out <= 1'b0;
      end
      else
      begin
         host_write_q <= 1'b0;
         // a frame cut short by deselect writes nothing
         if (cs_n_q)
         begin
            bit_cnt_q <= 4'h0;
            shift_out_q <= 8'h00;
            dout_out <= 1'b0;
         end
         else
         begin
            if (sclk_rise)
            begin
               shift_in_q <= rx_byte; // RQ2
               bit_cnt_q <= bit_cnt_q + 4'h1;
               if (bit_cnt_q == 4'h7)
               begin
                  is_read_q <= rx_byte[`CMD_READ_BIT];
                  hit_mode_q <= (rx_byte[`CMD_ADDR_HI:`CMD_ADDR_LO] ==
                                 `OPERATING_MODE_ADDR);
                  // read answers start on the next falling edge
                  if (rx_byte[`CMD_READ_BIT] &&
                      rx_byte[`CMD_ADDR_HI:`CMD_ADDR_LO] ==
                      `OPERATING_MODE_ADDR)
                     shift_out_q <= mode_q; // RQ1
                  else
                     shift_out_q <= 8'h00;
               end
               if (bit_cnt_q == 4'hF)
               begin
                  bit_cnt_q <= 4'h0;
                  if (hit_mode_q && !is_read_q)
                  begin
                     host_write_q <= 1'b1;
                     // reserved bits are never stored, so they read zero
                     host_data_q <= rx_byte & `MODE_WRITE_MASK; // RQ18
                  end
               end
            end
            if (sclk_fall && bit_cnt_q[3])
            begin
               dout_out <= shift_out_q[7]; // RQ2
               shift_out_q <= {shift_out_q[6:0], 1'b0};
            end
         end
      end
   end

   // ****************************************************************
   // mode register and sequencer
   // ****************************************************************
   wire [2:0] md = mode_q[`MODE_FIELD_HI:`MODE_FIELD_LO];
   wire [2:0] new_md = host_data_q[`MODE_FIELD_HI:`MODE_FIELD_LO];
   wire md_is_cal = md[2];
   reg [7:0] mode_d;

   always @*
   begin
      mode_d = mode_q;
      // only a host write or a completion moves the register
      if (host_write_q)
         mode_d = host_data_q; // RQ1
      else if (md == `MD_SINGLE && conv_done_in)
         mode_d[`MODE_FIELD_HI:`MODE_FIELD_LO] = `MD_IDLE; // RQ10
      else if (md_is_cal && cal_done_in)
         mode_d[`MODE_FIELD_HI:`MODE_FIELD_LO] = `MD_IDLE; // RQ17
   end

   // ****************************************************************
   // register update and event pulses
   // ****************************************************************
   always @(posedge sys_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         mode_q <= `OPERATING_MODE_RESET; // RQ1
         conv_reset_out <= 1'b0;
         ready_clear_out <= 1'b0;
         data_update_out <= 1'b0;
         status_write_out <= 1'b0;
         cal_reg_write_out <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         // a host write outranks a completion landing the same cycle
         conv_reset_out <= host_write_q; // RQ16
         ready_clear_out <= host_write_q &&
                            (new_md[2] || new_md == `MD_SINGLE ||
                             new_md == `MD_CONTINUOUS); // RQ17
         data_update_out <= !host_write_q && conv_done_in &&
                            (md == `MD_SINGLE ||
                             md == `MD_CONTINUOUS); // RQ11
         status_write_out <= !host_write_q &&
                             ((conv_done_in && (md == `MD_SINGLE ||
                               md == `MD_CONTINUOUS)) ||
                              (cal_done_in && md_is_cal)); // RQ10
         cal_reg_write_out <= !host_write_q && cal_done_in &&
                              md_is_cal; // RQ17
      end
   end

   // ****************************************************************
   // oscillator stop and restart
   // ****************************************************************
   // standby is power-down; counter spans the full restart time
   wire standby = (md == `MD_POWER_DOWN);
   wire osc_halt = standby && mode_q[`OSC_STOP_BIT];
   reg [23:0] osc_cnt_q;
   reg osc_stopped_q;

   always @(posedge sys_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         osc_cnt_q <= 24'h000000;
         osc_stopped_q <= 1'b0;
         osc_run_out <= 1'b1;
         osc_ready_out <= 1'b1;
      end
      else
      begin
         osc_run_out <= !osc_halt; // RQ7
         if (osc_halt)
         begin
            osc_stopped_q <= 1'b1; // RQ6
            osc_ready_out <= 1'b0;
            osc_cnt_q <= 24'h000000;
         end
         else if (osc_stopped_q)
         begin
            if (osc_cnt_q >= OSC_START_CYCLES - 24'h000001)
            begin
               osc_stopped_q <= 1'b0; // RQ6
               osc_ready_out <= 1'b1;
            end
            else
               osc_cnt_q <= osc_cnt_q + 24'h000001;
         end
         else
            // not halted and not restarting: the crystal runs, no restart wait
            osc_ready_out <= 1'b1; // RQ7
      end
   end

   // ****************************************************************
   // registered control outputs
   // ****************************************************************
   always @(posedge sys_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         operating_mode_field_out <= `MD_POWER_DOWN;
         buf_bypass_out <= 1'b0;
         main_pseudo_diff_out <= 1'b0;
         aux_pair_avail_out <= 1'b1;
         pll_enable_out <= 1'b0;
         conv_hold_reset_out <= 1'b1;
         cal_active_out <= 1'b0;
         short_inputs_out <= 1'b0;
         ref_to_input_out <= 1'b0;
      end
      else
      begin
         operating_mode_field_out <= md;
         buf_bypass_out <= mode_q[`BUF_BYPASS_BIT]; // RQ3
         main_pseudo_diff_out <= mode_q[`CHANNEL_CONFIG_BIT]; // RQ4
         aux_pair_avail_out <= !mode_q[`CHANNEL_CONFIG_BIT]; // RQ5
         pll_enable_out <= !standby; // RQ8
         // held until the crystal settles so no result uses a bad clock
         conv_hold_reset_out <= standby || md == `MD_IDLE ||
                                osc_stopped_q; // RQ9
         cal_active_out <= md_is_cal; // RQ17
         short_inputs_out <= (md == `MD_INT_ZERO_CAL); // RQ12
         ref_to_input_out <= (md == `MD_INT_FULL_CAL); // RQ13
      end
   end

endmodule

// *** test/adc_mode_control_props.sv ***
// Purpose: temporal checks on the mode sequencer ports
// Assumes: one clock domain, async active-high reset
// Notes: bound into every adc_mode_control instance
`timescale 1ns/1ps
module adc_mode_control_props (
   input wire sys_clk_in, // clock
   input wire sys_rst_in, // reset
   input wire conv_done_in, // result pulse
   input wire [2:0] operating_mode_field_out, // mode code
   input wire pll_enable_out, // pll on
   input wire conv_hold_reset_out, // converters held
   input wire short_inputs_out, // inputs shorted
   input wire ref_to_input_out, // reference routed
   input wire cal_active_out, // calibrating
   input wire main_pseudo_diff_out, // pseudo channels
   input wire aux_pair_avail_out, // aux pair usable
   input wire data_update_out, // data load pulse
   input wire cal_reg_write_out, // cal load pulse
   input wire status_write_out, // status pulse
   input wire ready_clear_out, // flags clear pulse
   input wire conv_reset_out, // converter reset pulse
   input wire osc_ready_out // oscillator settled
);
   // ******
   // checks
   // ******
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   wire [2:0] f = operating_mode_field_out;
   // levels may trail the code by a cycle, so judge settled codes only
   sequence held_s;
      $stable(f) [*2];
   endsequence
   a_pll_power_mode: assert property (
      held_s |-> pll_enable_out == (f != 3'h0))
      else $error("pll enable disagrees with mode");
   a_idle_hold_reset: assert property (
      (held_s and (f <= 3'h1)) |-> conv_hold_reset_out)
      else $error("converters not held in idle");
   a_zero_cal_short: assert property (
      held_s |-> short_inputs_out == (f == 3'h4))
      else $error("input short wrong");
   a_full_cal_ref: assert property (
      held_s |-> ref_to_input_out == (f == 3'h5))
      else $error("reference routing wrong");
   a_cal_active_codes: assert property (
      held_s |-> cal_active_out == f[2])
      else $error("calibration level wrong");
   a_aux_pair_inverse: assert property (
      aux_pair_avail_out != main_pseudo_diff_out)
      else $error("channel layout inconsistent");
   a_single_goes_idle: assert property (
      data_update_out && f == 3'h2 |=> f == 3'h1)
      else $error("single conversion did not end idle");
   a_continuous_stays: assert property (
      data_update_out && f == 3'h3 |=> f == 3'h3)
      else $error("continuous mode left");
   a_update_has_cause: assert property (
      data_update_out |-> $past(conv_done_in) && status_write_out)
      else $error("data update without result");
   a_cal_end_idle: assert property (
      cal_reg_write_out |-> status_write_out ##1 f == 3'h1)
      else $error("calibration did not end idle");
   // the code output trails the register, so the new code shows next
   a_clear_with_reset: assert property (
      ready_clear_out |-> conv_reset_out ##1
         (f >= 3'h2 && !conv_reset_out))
      else $error("ready clear without converter reset");
   a_restart_holds: assert property (
      !osc_ready_out |-> conv_hold_reset_out)
      else $error("converters run before oscillator");
   c_cal_done: cover property (cal_reg_write_out);
   c_cont_update: cover property (data_update_out && f == 3'h3);
   c_osc_restart: cover property (!osc_ready_out);
endmodule

bind adc_mode_control adc_mode_control_props adc_mode_control_props_i (
   .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
   .conv_done_in(conv_done_in),
   .operating_mode_field_out(operating_mode_field_out),
   .pll_enable_out(pll_enable_out), .conv_hold_reset_out(conv_hold_reset_out),
   .short_inputs_out(short_inputs_out), .ref_to_input_out(ref_to_input_out),
   .cal_active_out(cal_active_out),
   .main_pseudo_diff_out(main_pseudo_diff_out),
   .aux_pair_avail_out(aux_pair_avail_out), .data_update_out(data_update_out),
   .cal_reg_write_out(cal_reg_write_out), .status_write_out(status_write_out),
   .ready_clear_out(ready_clear_out), .conv_reset_out(conv_reset_out),
   .osc_ready_out(osc_ready_out));

// *** test/serial_host_model.sv ***
// Purpose: host processor on the four-wire serial link
// Assumes: 160 ns serial period, paced on system clock falls
// Notes: clock idles high, data set on falls, read before next fall
`timescale 1ns/1ps
module serial_host_model (
   input wire sys_clk_in, // pacing clock
   input wire dout_in, // device read data
   output logic sclk_out, // serial clock
   output logic cs_n_out, // select, active low
   output logic din_out // data to device
);
   initial
   begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      din_out = 1'b0;
   end
   task automatic half();
      repeat (4) @(negedge sys_clk_in);
   endtask
   task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
      int i;
      rx = 8'h00;
      cs_n_out = 1'b0;
      half();
      for (i = 15; i >= 0; i--)
      begin
         sclk_out = 1'b0;
         din_out = tx[i];
         half();
         sclk_out = 1'b1;
         half();
         if (i < 8) rx[i] = dout_in;
      end
      cs_n_out = 1'b1;
      din_out = ~din_out; // released line must not keep its value
      half();
      half();
   endtask
endmodule

// *** test/adc_mode_control_tb.sv ***
// Purpose: register-level test of the mode sequencer
// Assumes: restart count shortened to 40 cycles
// Notes: pulse outputs are judged by the bound checker
`timescale 1ns/1ps
module adc_mode_control_tb;
   logic sys_clk_in = 1'b0, sys_rst_in = 1'b1;
   logic conv_done_in = 1'b0, cal_done_in = 1'b0;
   wire sclk, cs_n, din, dout, bufb, pseudo, aux, orun, ordy, pll, hold;
   wire creset, cact, shrt, refi;
   wire [2:0] field;
   int failures = 0, checks_done = 0, resets = 0, n, c;
   logic [7:0] rd;
   always #10 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) if (creset === 1'b1) resets++;
   serial_host_model serial_host_model_i (.sys_clk_in(sys_clk_in),
      .dout_in(dout), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));
   adc_mode_control #(.OSC_START_CYCLES(24'h000028)) adc_mode_control_i (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk),
      .cs_n_in(cs_n), .din_in(din), .conv_done_in(conv_done_in),
      .cal_done_in(cal_done_in), .dout_out(dout),
      .operating_mode_field_out(field), .buf_bypass_out(bufb),
      .main_pseudo_diff_out(pseudo), .aux_pair_avail_out(aux),
      .osc_run_out(orun), .osc_ready_out(ordy), .pll_enable_out(pll),
      .conv_hold_reset_out(hold), .conv_reset_out(creset),
      .ready_clear_out(), .data_update_out(), .status_write_out(),
      .cal_reg_write_out(), .cal_active_out(cact),
      .short_inputs_out(shrt), .ref_to_input_out(refi));
   task automatic summarize();
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      serial_host_model_i.xfer({4'h0, a, d}, rd);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      serial_host_model_i.xfer({4'h4, a, 8'h00}, rd);
      chk("read data", e, rd);
   endtask
   task automatic done(input logic cal);
      @(negedge sys_clk_in);
      {cal_done_in, conv_done_in} = cal ? 2'h2 : 2'h1;
      @(negedge sys_clk_in);
      {cal_done_in, conv_done_in} = 2'h0;
      repeat (4) @(negedge sys_clk_in);
   endtask
   initial
   begin
      repeat (20) @(negedge sys_clk_in);
      sys_rst_in = 1'b0;
      repeat (8) @(negedge sys_clk_in);
      rd_chk(4'h1, 8'h00);
      wr(4'h1, 8'hFF);
      rd_chk(4'h1, 8'h5F);
      chk("config", 8'hD7, {bufb, pseudo, aux, cact, 1'b0, field});
      done(1'b1);
      rd_chk(4'h1, 8'h59);
      for (c = 0; c < 8; c++)
      begin
         wr(4'h1, 8'(c));
         chk("levels",
             {c != 0, c <= 1, c == 4, c == 5, 1'b1, c >= 4, 2'h2},
             {pll, hold, shrt, refi, orun, cact, aux, pseudo});
         chk("mode field", 8'(c), {4'h0, bufb, field});
      end
      wr(4'h1, 8'h02);
      done(1'b0);
      chk("single end", 8'h01, {5'h0, field});
      wr(4'h1, 8'h03);
      done(1'b0);
      chk("continuous", 8'h03, {5'h0, field});
      n = resets;
      wr(4'h1, 8'h03);
      chk("rewrite resets", 8'(n + 1), 8'(resets));
      wr(4'h2, 8'h00);
      rd_chk(4'h2, 8'h00);
      rd_chk(4'h1, 8'h03);
      wr(4'h1, 8'h08);
      chk("standby", 8'h00, {5'h0, orun, ordy, pll});
      wr(4'h1, 8'h09);
      chk("restart", 8'h05, {5'h0, orun, ordy, hold});
      for (n = 0; n < 60 && ordy !== 1'b1; n++) @(negedge sys_clk_in);
      chk("restart done", 8'h01, {7'h0, ordy});
      // 40-cycle count ends about 33 cycles after the write returns
      chk("restart wait", 8'h01, {7'h0, n > 24 && n < 42});
      wr(4'h1, 8'h00);
      wr(4'h1, 8'h01);
      chk("no restart", 8'h03, {6'h0, orun, ordy});
      summarize();
   end
endmodule
